// ===== inc/cal_corr_pkg.sv
// Shared constants and types for the conversion correction block.
package cal_corr_pkg;

    // Register bus geometry.
    localparam int ADDR_W = 8;
    localparam int DATA_W = 32;

    // Register byte offsets.
    localparam logic [7:0] OFS_CTRL = 8'h00;
    localparam logic [7:0] OFS_CHAN_SEL = 8'h04;
    localparam logic [7:0] OFS_CELL_GAIN = 8'h08;
    localparam logic [7:0] OFS_CELL_OFFSET = 8'h0c;
    localparam logic [7:0] OFS_STATUS = 8'h10;
    // Extra-input offsets sit at 0x20 + 4*n.
    localparam logic [2:0] AUX_PAGE = 3'h1;
    localparam int AUX_PAGE_LSB = 5;
    localparam int AUX_IDX_LSB = 2;

    // Field layouts.
    localparam int CTRL_PCTL_BIT = 0;
    localparam int CTRL_AFE_BIT = 1;
    localparam int ST_PARK_LSB = 0;
    localparam int ST_PCTL_EFF_BIT = 4;
    localparam int ST_BUSY_BIT = 5;
    localparam int ST_PENDING_BIT = 6;

    // Widths of the channel sets and the correction fields.
    localparam int NUM_CELLS = 16;
    localparam int NUM_AUX = 8;
    localparam int CHAN_W = 4;
    localparam int AUX_W = 3;
    localparam int CODE_W = 16;
    localparam int GAIN_W = 8;
    localparam int CELL_OFS_W = 8;
    localparam int AUX_OFS_W = 10;

    // The gain term is in 1/2^16 of full scale.
    localparam int GAIN_SHIFT = 16;
    localparam logic [CODE_W-1:0] CODE_MAX = 16'hffff;

    // Reset values.
    localparam logic [NUM_CELLS-1:0] CHAN_SEL_RST = 16'hffff;
    localparam logic [GAIN_W-1:0] GAIN_RST = 8'h00;
    localparam logic [CELL_OFS_W-1:0] CELL_OFS_RST = 8'h00;
    localparam logic [AUX_OFS_W-1:0] AUX_OFS_RST = 10'h000;

    // Sampling delay before each sampling start while the front-end power control bit is in effect.
    localparam int SAMPLE_DELAY_US = 100;
    localparam int CLK_PERIOD_NS = 4;
    localparam int SAMPLE_DELAY_CYCLES = SAMPLE_DELAY_US * 1000 / CLK_PERIOD_NS;

    typedef struct packed {
        logic valid;
        logic is_aux;
        logic [CHAN_W-1:0] chan;
        logic [CODE_W-1:0] code;
    } sample_t;

    typedef enum logic [2:0] {
        SEQ_IDLE = 3'b001,
        SEQ_DELAY = 3'b010,
        SEQ_START = 3'b100
    } seq_state_t;

endpackage

// ===== rtl/result_corrector.sv
// Datapath that applies the user gain and offset terms to one result.
module result_corrector (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic rst_n_i,
    // Correction terms.
    input wire logic apply_gain_i,
    input wire logic [cal_corr_pkg::GAIN_W-1:0] gain_i,
    input wire logic [cal_corr_pkg::AUX_OFS_W-1:0] offset_i,
    // Result stream.
    input wire cal_corr_pkg::sample_t raw_i,
    output cal_corr_pkg::sample_t corr_o
);
    import cal_corr_pkg::*;

    sample_t res_q;
    sample_t res_d;
    logic signed [GAIN_W+CODE_W:0] prod;
    logic signed [CODE_W+2:0] sum;

    always_comb begin
        res_d = raw_i;
        // Gain scales with the code, so half scale gets half the correction.
        prod = $signed(apply_gain_i ? gain_i : GAIN_RST) * $signed({1'b0, raw_i.code});
        // Raw code here already carries the factory corrections.
        sum = $signed({3'b000, raw_i.code})
            + $signed({{(CODE_W+3-AUX_OFS_W){offset_i[AUX_OFS_W-1]}}, offset_i})
            + $signed({{2{prod[GAIN_W+CODE_W]}}, prod[GAIN_W+CODE_W:GAIN_SHIFT]});
        if (sum < 0) begin
            res_d.code = '0;
        end else if (sum > $signed({3'b000, CODE_MAX})) begin
            res_d.code = CODE_MAX;
        end else begin
            res_d.code = sum[CODE_W-1:0];
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_i) begin
        if (!rst_n_i) begin
            res_q <= '0;
        end else begin
            res_q <= res_d;
        end
    end

    assign corr_o = res_q;

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_i);

    AST_ZERO_TERMS: assert property (
        raw_i.valid && gain_i == 8'h00 && offset_i == 10'h000
        |=> corr_o.code == $past(raw_i.code))
        else $error("Zero terms changed the result.");
    AST_NO_GAIN_AUX: assert property (
        raw_i.valid && !apply_gain_i && offset_i == 10'h000
        |=> corr_o.code == $past(raw_i.code))
        else $error("Gain leaked into an extra-input result.");
    AST_HALF_SCALE: assert property (
        raw_i.valid && apply_gain_i && offset_i == 10'h000 && raw_i.code == 16'h8000
        |=> $signed({1'b0, corr_o.code}) == 17'sh08000 + $signed($past(gain_i)) / 2
            - ($past(gain_i[7]) && $past(gain_i[0]) ? 1 : 0))
        else $error("Half-scale gain correction is not half of full scale.");
    COV_AUX: cover property (raw_i.valid && raw_i.is_aux && offset_i != 10'h000);
endmodule

// ===== rtl/adc_calibration_correction.sv
// Register file, parking, sampling delay and result correction for the monitor ADC.
//
// Design decisions made here: the placing of the registers and the Avalon-MM register port.
module adc_calibration_correction #(
    parameter int DELAY_CYCLES = cal_corr_pkg::SAMPLE_DELAY_CYCLES
) (
    // Clock and reset.
    input wire logic mclk_i,
    input wire logic resetn_i,
    // Avalon-MM slave.
    input wire logic [cal_corr_pkg::ADDR_W-1:0] avs_address_i,
    input wire logic avs_read_i,
    input wire logic avs_write_i,
    input wire logic [cal_corr_pkg::DATA_W-1:0] avs_writedata_i,
    output logic [cal_corr_pkg::DATA_W-1:0] avs_readdata_o,
    output logic avs_waitrequest_o,
    // Front-end sequencing.
    input wire logic sample_req_i,
    input wire logic afe_sample_done_i,
    output logic sample_start_o,
    output logic [cal_corr_pkg::CHAN_W-1:0] park_channel_o,
    output logic front_end_power_control_bit_o,
    output logic front_end_control_bit_o,
    output logic upward_stack_transmitter_en_o,
    // Results.
    input wire cal_corr_pkg::sample_t raw_i,
    output cal_corr_pkg::sample_t corr_o
);
    import cal_corr_pkg::*;

    localparam int CNT_W = $clog2(DELAY_CYCLES + 1);

    // Reset release.
    logic rst_meta_q;
    logic rst_n_q;

    always_ff @(posedge mclk_i or negedge resetn_i) begin
        if (!resetn_i) begin
            rst_meta_q <= 1'b0;
            rst_n_q <= 1'b0;
        end else begin
            rst_meta_q <= 1'b1;
            rst_n_q <= rst_meta_q;
        end
    end

    // Register file and bus slave state.
    logic ack_q;
    logic ack_d;
    logic [DATA_W-1:0] rdata_q;
    logic [DATA_W-1:0] rdata_d;
    logic pctl_req_q;
    logic pctl_req_d;
    logic front_end_control_bit_q;
    logic front_end_control_bit_d;
    logic [NUM_CELLS-1:0] chan_sel_q;
    logic [NUM_CELLS-1:0] chan_sel_d;
    logic [GAIN_W-1:0] cell_gain_correction_q;
    logic [GAIN_W-1:0] cell_gain_correction_d;
    logic [CELL_OFS_W-1:0] cell_offset_correction_q;
    logic [CELL_OFS_W-1:0] cell_offset_correction_d;
    logic [AUX_OFS_W-1:0] aux_offset_q [NUM_AUX];
    logic [AUX_OFS_W-1:0] aux_offset_d [NUM_AUX];
    logic req;
    logic wr_en;
    logic aux_hit;
    logic [AUX_W-1:0] aux_idx;

    // Sequencer state.
    seq_state_t st_q;
    seq_state_t st_d;
    logic [CNT_W-1:0] cnt_q;
    logic [CNT_W-1:0] cnt_d;
    logic pctl_eff_q;
    logic pctl_eff_d;
    logic [CHAN_W-1:0] park_q;
    logic [CHAN_W-1:0] park_d;
    logic tx_en_q;

    assign req = avs_read_i || avs_write_i;
    // A request waits one cycle, then completes in the cycle waitrequest drops.
    assign avs_waitrequest_o = req && !ack_q;
    assign wr_en = avs_write_i && ack_q;
    assign aux_hit = avs_address_i[ADDR_W-1:AUX_PAGE_LSB] == AUX_PAGE;
    assign aux_idx = avs_address_i[AUX_PAGE_LSB-1:AUX_IDX_LSB];

    always_comb begin
        ack_d = req && !ack_q;
        rdata_d = rdata_q;
        pctl_req_d = pctl_req_q;
        front_end_control_bit_d = front_end_control_bit_q;
        chan_sel_d = chan_sel_q;
        cell_gain_correction_d = cell_gain_correction_q;
        cell_offset_correction_d = cell_offset_correction_q;
        aux_offset_d = aux_offset_q;
        if (avs_read_i && !ack_q) begin
            rdata_d = '0;
            if (aux_hit) begin
                rdata_d[AUX_OFS_W-1:0] = aux_offset_q[aux_idx];
            end else begin
                case (avs_address_i)
                    OFS_CTRL: begin
                        rdata_d[CTRL_PCTL_BIT] = pctl_req_q;
                        rdata_d[CTRL_AFE_BIT] = front_end_control_bit_q;
                    end
                    OFS_CHAN_SEL: rdata_d[NUM_CELLS-1:0] = chan_sel_q;
                    OFS_CELL_GAIN: rdata_d[GAIN_W-1:0] = cell_gain_correction_q;
                    OFS_CELL_OFFSET: rdata_d[CELL_OFS_W-1:0] = cell_offset_correction_q;
                    OFS_STATUS: begin
                        rdata_d[ST_PARK_LSB +: CHAN_W] = park_q;
                        rdata_d[ST_PCTL_EFF_BIT] = pctl_eff_q;
                        rdata_d[ST_BUSY_BIT] = st_q != SEQ_IDLE;
                        rdata_d[ST_PENDING_BIT] = pctl_eff_q != pctl_req_q;
                    end
                    default: rdata_d = '0;
                endcase
            end
        end
        if (wr_en) begin
            if (aux_hit) begin
                aux_offset_d[aux_idx] = avs_writedata_i[AUX_OFS_W-1:0];
            end else begin
                case (avs_address_i)
                    OFS_CTRL: begin
                        pctl_req_d = avs_writedata_i[CTRL_PCTL_BIT];
                        front_end_control_bit_d = avs_writedata_i[CTRL_AFE_BIT];
                    end
                    OFS_CHAN_SEL: chan_sel_d = avs_writedata_i[NUM_CELLS-1:0];
                    OFS_CELL_GAIN: cell_gain_correction_d = avs_writedata_i[GAIN_W-1:0];
                    OFS_CELL_OFFSET: begin
                        cell_offset_correction_d = avs_writedata_i[CELL_OFS_W-1:0];
                    end
                    default: ;
                endcase
            end
        end
    end

    always_ff @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            ack_q <= 1'b0;
            rdata_q <= '0;
            pctl_req_q <= 1'b0;
            front_end_control_bit_q <= 1'b0;
            chan_sel_q <= CHAN_SEL_RST;
            cell_gain_correction_q <= GAIN_RST;
            cell_offset_correction_q <= CELL_OFS_RST;
            for (int i = 0; i < NUM_AUX; i++) begin
                aux_offset_q[i] <= AUX_OFS_RST;
            end
        end else begin
            ack_q <= ack_d;
            rdata_q <= rdata_d;
            pctl_req_q <= pctl_req_d;
            front_end_control_bit_q <= front_end_control_bit_d;
            chan_sel_q <= chan_sel_d;
            cell_gain_correction_q <= cell_gain_correction_d;
            cell_offset_correction_q <= cell_offset_correction_d;
            aux_offset_q <= aux_offset_d;
        end
    end

    // Sampling sequencer; a request that arrives while one is pending is dropped.
    always_comb begin
        st_d = st_q;
        cnt_d = cnt_q;
        pctl_eff_d = pctl_eff_q;
        park_d = '0;
        for (int i = 0; i < NUM_CELLS; i++) begin
            if (chan_sel_q[i]) begin
                park_d = CHAN_W'(i);
            end
        end
        if (afe_sample_done_i) begin
            pctl_eff_d = pctl_req_q;
        end
        case (st_q)
            SEQ_IDLE: begin
                if (sample_req_i) begin
                    if (pctl_eff_q) begin
                        st_d = SEQ_DELAY;
                        cnt_d = CNT_W'(DELAY_CYCLES);
                    end else begin
                        st_d = SEQ_START;
                    end
                end
            end
            SEQ_DELAY: begin
                cnt_d = cnt_q - 1'b1;
                if (cnt_q == CNT_W'(1)) begin
                    st_d = SEQ_START;
                end
            end
            SEQ_START: st_d = SEQ_IDLE;
            default: st_d = SEQ_IDLE;
        endcase
    end

    always_ff @(posedge mclk_i or negedge rst_n_q) begin
        if (!rst_n_q) begin
            st_q <= SEQ_IDLE;
            cnt_q <= '0;
            pctl_eff_q <= 1'b0;
            park_q <= '0;
            tx_en_q <= 1'b1;
        end else begin
            st_q <= st_d;
            cnt_q <= cnt_d;
            pctl_eff_q <= pctl_eff_d;
            park_q <= park_d;
            tx_en_q <= 1'b1;
        end
    end

    assign sample_start_o = st_q == SEQ_START;
    assign park_channel_o = park_q;
    assign front_end_power_control_bit_o = pctl_eff_q;
    assign front_end_control_bit_o = front_end_control_bit_q;
    assign upward_stack_transmitter_en_o = tx_en_q;
    assign avs_readdata_o = rdata_q;

    // Cell results take the global terms; extra inputs take only their own offset.
    logic apply_gain;
    logic [AUX_OFS_W-1:0] sel_offset;

    assign apply_gain = !raw_i.is_aux;
    assign sel_offset = raw_i.is_aux ? aux_offset_q[raw_i.chan[AUX_W-1:0]]
        : {{(AUX_OFS_W-CELL_OFS_W){cell_offset_correction_q[CELL_OFS_W-1]}},
           cell_offset_correction_q};

    result_corrector u_corr (
        .mclk_i(mclk_i),
        .rst_n_i(rst_n_q),
        .apply_gain_i(apply_gain),
        .gain_i(cell_gain_correction_q),
        .offset_i(sel_offset),
        .raw_i(raw_i),
        .corr_o(corr_o)
    );

    default clocking cb @(posedge mclk_i); endclocking
    default disable iff (!rst_n_q);

    AST_PARK_HIGHEST: assert property (
        chan_sel_q != 16'h0000 && $stable(chan_sel_q)
        |=> ($past(chan_sel_q) >> park_q) == 16'h0001)
        else $error("Parked channel is not the highest enabled one.");
    AST_DELAY_LOAD: assert property (
        st_q == SEQ_IDLE && sample_req_i && pctl_eff_q
        |=> st_q == SEQ_DELAY && cnt_q == CNT_W'(DELAY_CYCLES) && !sample_start_o)
        else $error("Delayed sampling did not load the full count.");
    AST_DELAY_END: assert property (
        st_q == SEQ_DELAY && cnt_q == CNT_W'(1) |=> sample_start_o ##1 !sample_start_o)
        else $error("Sampling did not start when the delay expired.");
    AST_NO_DELAY: assert property (
        st_q == SEQ_IDLE && sample_req_i && !pctl_eff_q |=> sample_start_o)
        else $error("Undelayed sampling did not start at once.");
    AST_PCTL_HOLD: assert property (
        !afe_sample_done_i |=> $stable(pctl_eff_q))
        else $error("Power control changed before a front-end sample.");
    AST_PCTL_TAKE: assert property (
        afe_sample_done_i |=> pctl_eff_q == $past(pctl_req_q))
        else $error("Power control not taken at sample completion.");
    AST_GAIN_WRITE: assert property (
        wr_en && !aux_hit && avs_address_i == OFS_CELL_GAIN
        |=> cell_gain_correction_q == $past(avs_writedata_i[GAIN_W-1:0]))
        else $error("Gain write was lost.");
    AST_OFFSET_WRITE: assert property (
        wr_en && !aux_hit && avs_address_i == OFS_CELL_OFFSET
        |=> cell_offset_correction_q == $past(avs_writedata_i[CELL_OFS_W-1:0]))
        else $error("Offset write was lost.");
    AST_TX_ON: assert property (
        upward_stack_transmitter_en_o)
        else $error("Upward transmitter was disabled.");
    AST_BUS_ANSWER: assert property (
        req && !ack_q |=> !(req && avs_waitrequest_o))
        else $error("Bus request not answered in the second cycle.");

    COV_DELAYED: cover property (st_q == SEQ_DELAY && cnt_q == CNT_W'(1));
    COV_PCTL_CHANGE: cover property (afe_sample_done_i && pctl_req_q != pctl_eff_q);
    COV_AUX_WRITE: cover property (wr_en && aux_hit);
endmodule

// ===== testbench/host_model.sv
// Host-side register master that writes and reads the calibration registers.
module host_model (
    // Clock.
    input wire logic mclk_i,
    // Avalon-MM master side.
    output logic [cal_corr_pkg::ADDR_W-1:0] avs_address_o,
    output logic avs_read_o,
    output logic avs_write_o,
    output logic [cal_corr_pkg::DATA_W-1:0] avs_writedata_o,
    input wire logic [cal_corr_pkg::DATA_W-1:0] avs_readdata_i,
    input wire logic avs_waitrequest_i
);
    timeunit 1ns;
    timeprecision 1ps;
    import cal_corr_pkg::*;

    // Store-side offsets and key values; this block does not decode them, values are arbitrary.
    localparam logic [7:0] KEY_ONE_OFS = 8'h80;
    localparam logic [7:0] KEY_TWO_OFS = 8'h84;
    localparam logic [7:0] STORE_OFS = 8'h88;
    localparam logic [7:0] CSUM_OFS = 8'h8c;
    localparam logic [31:0] UNLOCK_KEY_ONE = 32'h00005a3c;
    localparam logic [31:0] UNLOCK_KEY_TWO = 32'h0000c3a5;

    initial begin
        avs_address_o = 8'h00;
        avs_read_o = 1'b0;
        avs_write_o = 1'b0;
        avs_writedata_o = 32'h0;
    end

    // Called at a rising edge; holds the request until waitrequest is seen low at an edge.
    task automatic xfer(input logic wr, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] q);
        avs_address_o <= a;
        avs_write_o <= wr;
        avs_read_o <= ~wr;
        avs_writedata_o <= d;
        do begin
            @(posedge mclk_i);
        end while (avs_waitrequest_i !== 1'b0);
        q = avs_readdata_i;
        avs_read_o <= 1'b0;
        avs_write_o <= 1'b0;
        @(posedge mclk_i);
    endtask

    // A term outside the signed byte range is saturated, then only the low byte is kept.
    function automatic logic [7:0] to_byte(input int v);
        int s;
        s = (v > 127) ? 127 : ((v < -128) ? -128 : v);
        return s[7:0];
    endfunction

    // The term is given in 16-bit result units referred to full scale.
    task automatic put_term(input logic [7:0] a, input int v);
        logic [31:0] q;
        xfer(1'b1, a, {24'h0, to_byte(v)}, q);
    endtask

    // Keys first, then the store bit, then a fresh checksum over the stored terms.
    task automatic persist(input logic [7:0] gn, input logic [7:0] of);
        logic [31:0] q;
        xfer(1'b1, KEY_ONE_OFS, UNLOCK_KEY_ONE, q);
        xfer(1'b1, KEY_TWO_OFS, UNLOCK_KEY_TWO, q);
        xfer(1'b1, STORE_OFS, 32'h00000001, q);
        xfer(1'b1, CSUM_OFS, {24'h0, gn + of}, q);
    endtask
endmodule

// ===== testbench/adc_calibration_correction_tb.sv
// Self-checking bench for the conversion correction block.
module adc_calibration_correction_tb;
    timeunit 1ns;
    timeprecision 1ps;
    import cal_corr_pkg::*;
    localparam int DLY = 20;
    logic mclk_i, resetn_i, sample_req_i, afe_sample_done_i;
    logic [ADDR_W-1:0] avs_address;
    logic avs_read, avs_write, avs_waitrequest, sample_start_o, pctl_o, fctl_o, up_en_o;
    logic [DATA_W-1:0] avs_writedata, avs_readdata, q, seed;
    logic [3:0] park_o;
    logic [7:0] g, o;
    logic [9:0] ao;
    logic [2:0] a;
    logic [15:0] c, sel;
    logic [15:0] corner [4] = '{16'h0001, 16'h8000, 16'h0000, 16'h0a50};
    sample_t raw_i, corr_o;
    int fails, checks_done, n;

    adc_calibration_correction #(.DELAY_CYCLES(DLY)) DUT (.mclk_i(mclk_i), .resetn_i(resetn_i),
        .avs_address_i(avs_address), .avs_read_i(avs_read), .avs_write_i(avs_write),
        .avs_writedata_i(avs_writedata), .avs_readdata_o(avs_readdata),
        .avs_waitrequest_o(avs_waitrequest), .sample_req_i(sample_req_i),
        .afe_sample_done_i(afe_sample_done_i), .sample_start_o(sample_start_o),
        .park_channel_o(park_o), .front_end_power_control_bit_o(pctl_o),
        .front_end_control_bit_o(fctl_o), .upward_stack_transmitter_en_o(up_en_o),
        .raw_i(raw_i), .corr_o(corr_o));

    host_model host (.mclk_i(mclk_i), .avs_address_o(avs_address), .avs_read_o(avs_read),
        .avs_write_o(avs_write), .avs_writedata_o(avs_writedata),
        .avs_readdata_i(avs_readdata), .avs_waitrequest_i(avs_waitrequest));

    initial begin
        mclk_i = 1'b0;
        forever #2 mclk_i = ~mclk_i;
    end

    function automatic logic [31:0] lfsr(input logic [31:0] s);
        return {s[30:0], s[31] ^ s[21] ^ s[1] ^ s[0]};
    endfunction

    function automatic logic [31:0] park_of(input logic [15:0] s);
        park_of = 32'h0;
        for (int i = 0; i < 16; i++) if (s[i]) park_of = i;
    endfunction

    function automatic logic [31:0] fix_code(input logic [15:0] cd, input logic signed [7:0] gn,
                                             input logic signed [9:0] of);
        int v;
        v = int'(cd) + int'(of) + ((int'(gn) * int'(cd)) >>> 16);
        v = (v < 0) ? 0 : ((v > 65535) ? 65535 : v);
        return v;
    endfunction

    task automatic check(input string what, input logic [31:0] seen, input logic [31:0] exp);
        checks_done++;
        if (seen !== exp) begin
            fails++;
            $display("CHECK FAILED %s expected %h seen %h", what, exp, seen);
        end
    endtask

    task automatic results();
        $display("checks %0d mismatches %0d", checks_done, fails);
        if (fails == 0 && checks_done > 0) $display("NO MISMATCHES");
        else $display("MISMATCHES SEEN");
        $finish;
    endtask

    task automatic put(input logic [7:0] ad, input logic [31:0] d);
        host.xfer(1'b1, ad, d, q);
    endtask

    task automatic reg_is(input string what, input logic [7:0] ad, input logic [31:0] e);
        host.xfer(1'b0, ad, 32'h0, q);
        check(what, q, e);
    endtask

    // Holds the raw result for two edges so the registered output can be compared.
    task automatic sample(input logic aux, input logic [3:0] ch, input logic [31:0] e);
        raw_i <= '{valid: 1'b1, is_aux: aux, chan: ch, code: c};
        repeat (2) @(posedge mclk_i);
        check("corrected code", {16'h0, corr_o.code}, e);
        check("result tag", {26'h0, corr_o.valid, corr_o.is_aux, corr_o.chan},
              {26'h0, 1'b1, aux, ch});
    endtask

    task automatic req_latency(output int lat);
        sample_req_i <= 1'b1;
        @(posedge mclk_i);
        sample_req_i <= 1'b0;
        lat = 0;
        do begin
            @(posedge mclk_i);
            lat++;
        end while (sample_start_o !== 1'b1);
    endtask

    initial begin
        repeat (20000) @(posedge mclk_i);
        fails++;
        results();
    end

    initial begin
        fails = 0;
        checks_done = 0;
        seed = 32'd88931;
        resetn_i = 1'b0;
        sample_req_i = 1'b0;
        afe_sample_done_i = 1'b0;
        raw_i = '0;
        repeat (10) @(posedge mclk_i);
        resetn_i <= 1'b1;
        repeat (4) @(posedge mclk_i);
        check("upward transmitter", {31'h0, up_en_o}, 32'h1);
        check("park after reset", {28'h0, park_o}, 32'hf);
        reg_is("channel select", OFS_CHAN_SEL, 32'hffff);
        reg_is("gain reset", OFS_CELL_GAIN, 32'h0);
        reg_is("offset reset", OFS_CELL_OFFSET, 32'h0);
        reg_is("status reset", OFS_STATUS, 32'hf);
        reg_is("unmapped", 8'h40, 32'h0);
        put(OFS_CELL_GAIN, 32'hffffffff);
        reg_is("gain width", OFS_CELL_GAIN, 32'hff);
        put(OFS_CELL_OFFSET, 32'hffffffff);
        reg_is("offset width", OFS_CELL_OFFSET, 32'hff);
        for (int i = 0; i < NUM_AUX; i++) begin
            put(8'h20 + 8'(4 * i), 32'hfffffc00 | 32'(i * 73 + 1));
            reg_is("aux offset", 8'h20 + 8'(4 * i), 32'(i * 73 + 1));
        end
        host.put_term(OFS_CELL_GAIN, 300);
        reg_is("gain saturated high", OFS_CELL_GAIN, 32'h7f);
        host.put_term(OFS_CELL_OFFSET, -500);
        reg_is("offset saturated low", OFS_CELL_OFFSET, 32'h80);
        host.persist(8'h7f, 8'h80);
        reg_is("gain after store", OFS_CELL_GAIN, 32'h7f);
        reg_is("offset after store", OFS_CELL_OFFSET, 32'h80);
        for (int i = 0; i < 10; i++) begin
            sel = (i < 4) ? corner[i] : seed[15:0];
            seed = lfsr(seed);
            put(OFS_CHAN_SEL, {16'h0, sel});
            repeat (2) @(posedge mclk_i);
            check("park channel", {28'h0, park_o}, park_of(sel));
        end
        for (int i = 0; i < 40; i++) begin
            {a, ao, o, g} = seed[28:0];
            seed = lfsr(seed);
            c = (i == 2) ? 16'hffff : ((i == 3) ? 16'h0000 : seed[15:0]);
            if (i == 4) c = 16'h8000;
            if (i < 2) {g, o} = 16'h0;
            if (i == 2) {g, o} = 16'h7f7f;
            if (i == 3) o = 8'h80;
            if (i == 4) o = 8'h00;
            put(OFS_CELL_GAIN, {24'h0, g});
            put(OFS_CELL_OFFSET, {24'h0, o});
            put(8'h20 + {3'h0, a, 2'h0}, {22'h0, ao});
            sample(1'b0, seed[19:16], fix_code(c, g, {{2{o[7]}}, o}));
            sample(1'b1, {1'b0, a}, fix_code(c, 8'h00, ao));
        end
        raw_i <= '0;
        req_latency(n);
        check("start latency idle", 32'(n), 32'h1);
        put(OFS_CTRL, 32'h3);
        repeat (2) @(posedge mclk_i);
        check("power bit pending", {31'h0, pctl_o}, 32'h0);
        check("front-end control", {31'h0, fctl_o}, 32'h1);
        reg_is("status pending", OFS_STATUS, park_of(sel) | (32'h1 << ST_PENDING_BIT));
        req_latency(n);
        check("start latency pending", 32'(n), 32'h1);
        afe_sample_done_i <= 1'b1;
        @(posedge mclk_i);
        afe_sample_done_i <= 1'b0;
        repeat (3) @(posedge mclk_i);
        check("power bit effective", {31'h0, pctl_o}, 32'h1);
        reg_is("status effective", OFS_STATUS, park_of(sel) | (32'h1 << ST_PCTL_EFF_BIT));
        for (int i = 0; i < 2; i++) begin
            req_latency(n);
            check("start latency delayed", 32'(n), 32'(DLY + 1));
        end
        results();
    end
endmodule
